// ==== fsw_watchdog_reset.sv ====
// Fail-safe watchdog and system reset controller with a classic Wishbone register slave.
`timescale 1ns/1ps
module fsw_watchdog_reset
	import fsw_pkg::*;
#(
	parameter int TICK_CYCLES_P = TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic rst_pin_i,
	output logic rst_pin_o,
	output logic rst_pin_oe_o,
	input wire logic supply_ok_i,
	input wire logic cur_above_low_i,
	input wire logic cur_above_high_i,
	input wire logic wake_i,
	input wire logic irq_unserved_i,
	output logic timeout_irq_o,
	output logic restart_irq_o,
	output logic failsafe_o
);

	// Pin synchroniser stages and the agreed value; bit 0 pin, 1 supply, 2 low, 3 high.
	logic [3:0] s1_ff, s2_ff, s3_ff, flt_ff;
	logic [15:0] tick_cnt_ff; // Oscillator divider.
	logic tick; // One-cycle watchdog tick.
	logic ack_ff; // Bus acknowledge.
	logic [31:0] rd_ff; // Bus read data.
	fsw_mode_reg_t mode_ff; // Last mode register value written with legal mode and period codes.
	logic rls_ff, tie_ff, rie_ff; // Length select and interrupt enables.
	fsw_state_t state_ff, nxt_state;
	logic [15:0] wd_cnt_ff, limit_ff, nxt_limit, cur_limit;
	logic run_ff, nxt_run, off_ff, nxt_off, miss_ff, nxt_miss, armed_ff, nxt_armed;
	logic [1:0] seq_ff, nxt_seq; // Progress through the flash entry sequence.
	logic rst_active_ff, rel_chk_ff, por_pend_ff, sup_prev_ff, pin_prev_ff, oe_ff;
	logic [4:0] rst_cnt_ff, clamp_cnt_ff;
	logic [3:0] src_ff, evt_src, fail_src;
	logic t_irq_ff, r_irq_ff, fs_ff;
	logic bus_req, mode_wr, cfg_wr, legal, expired, wd_clear, fail_evt, go_fs, restart;
	logic tie_clr, t_irq, r_irq, por, low_sup, ext_fall, hw_evt, evt, clamp_fs;
	fsw_mode_reg_t wr_val;
	fsw_period_t per;
	logic [15:0] new_limit;

	// Three-stage synchroniser; a bit changes only once stages two and three agree.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_ff <= 4'h1;
			s2_ff <= 4'h1;
			s3_ff <= 4'h1;
			flt_ff <= 4'h1;
		end else if (ce_i) begin
			s1_ff <= {cur_above_high_i, cur_above_low_i, supply_ok_i, rst_pin_i};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			flt_ff <= (s2_ff & s3_ff) | (flt_ff & (s2_ff ^ s3_ff));
		end
	end

	// The tick comes from the on-chip oscillator only, never from a host clock.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_ff <= 16'h0000;
		end else if (ce_i) begin
			// Restarting on a reset event makes a pulse last whole ticks, never a fraction of one.
			if (tick || evt) begin
				tick_cnt_ff <= 16'h0000;
			end else begin
				tick_cnt_ff <= 16'(tick_cnt_ff + 16'h0001);
			end
		end
	end
	assign tick = ce_i && (tick_cnt_ff == 16'(TICK_CYCLES_P - 1));

	// Bus decode; a mode write needs the two low byte lanes, since fields span both.
	assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
	assign mode_wr = bus_req && wb_we_i && (wb_adr_i == REG_MODE) && (&wb_sel_i[1:0]);
	assign cfg_wr = bus_req && wb_we_i && (wb_adr_i == REG_CONFIG) && wb_sel_i[0];
	assign wr_val = fsw_mode_reg_t'(wb_dat_i);
	assign per = fsw_period(wr_val.period);
	assign legal = per.ok && fsw_mode_ok(wr_val.mode);
	assign new_limit = fsw_scale(per.ms, wr_val.presc);

	// Slave answers one cycle after the request; unmapped reads return zero.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			rd_ff <= 32'h0000_0000;
		end else if (ce_i) begin
			ack_ff <= bus_req;
			if (bus_req && !wb_we_i) begin
				unique case (wb_adr_i)
					REG_MODE: rd_ff <= mode_ff;
					REG_CONFIG: rd_ff <= {29'h0, rie_ff, tie_ff, rls_ff};
					REG_STATUS: rd_ff <= {22'h0, miss_ff, armed_ff, run_ff, state_ff, src_ff};
					default: rd_ff <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Current start-up limit or programmed period, and the overflow condition.
	assign cur_limit = (state_ff == ST_STARTUP) ? STARTUP_TICKS : limit_ff;
	assign expired = run_ff && !rst_active_ff && (wd_cnt_ff >= cur_limit);

	// Watchdog decisions per state; a reset request here is taken only outside a pulse.
	always_comb begin
		nxt_state = state_ff;
		nxt_limit = limit_ff;
		nxt_run = run_ff;
		nxt_off = off_ff;
		nxt_miss = miss_ff;
		nxt_armed = armed_ff;
		nxt_seq = seq_ff;
		wd_clear = 1'b0;
		fail_evt = 1'b0;
		fail_src = SRC_WATCHDOG;
		go_fs = 1'b0;
		restart = 1'b0;
		tie_clr = 1'b0;
		t_irq = 1'b0;
		r_irq = 1'b0;
		if (!rst_active_ff) begin
			unique case (state_ff)
				ST_STARTUP: begin
					if (mode_wr && !legal) begin
						fail_evt = 1'b1;
						fail_src = per.ok ? SRC_ILLEGAL : SRC_WATCHDOG;
					end else if (mode_wr) begin
						wd_clear = 1'b1;
						nxt_limit = new_limit;
						nxt_miss = 1'b0;
						nxt_armed = 1'b0; // Any handshake uses up the flash entry.
						nxt_seq = 2'h0;
						nxt_off = wr_val.wd_off;
						if (wr_val.mode == MODE_NORMAL) begin
							nxt_state = ST_NORMAL;
						end else if (wr_val.mode == MODE_STANDBY) begin
							nxt_state = armed_ff ? ST_FLASH : ST_STANDBY;
						end else if (wr_val.mode == MODE_SLEEP) begin
							nxt_state = ST_SLEEP;
						end else begin
							fail_evt = 1'b1;
							fail_src = SRC_ILLEGAL;
						end
					end else if (expired && miss_ff) begin
						go_fs = 1'b1;
					end else if (expired) begin
						fail_evt = 1'b1;
						nxt_miss = 1'b1;
						restart = 1'b1;
					end
				end
				ST_NORMAL: begin
					if (expired) begin
						fail_evt = 1'b1;
					end else if (mode_wr && !legal) begin
						fail_evt = 1'b1;
						fail_src = per.ok ? SRC_ILLEGAL : SRC_WATCHDOG;
					end else if (mode_wr && (wd_cnt_ff < (limit_ff >> 1))) begin
						fail_evt = 1'b1;
					end else if (mode_wr) begin
						wd_clear = 1'b1;
						nxt_limit = new_limit;
						nxt_off = wr_val.wd_off;
						nxt_seq = (wr_val.mode == MODE_FLASH_SERVE) ? 2'h1 : 2'h0;
						unique case (wr_val.mode)
							MODE_NORMAL: nxt_state = ST_NORMAL;
							MODE_STANDBY: begin
								nxt_state = ST_STANDBY;
								if (wr_val.wd_off) begin
									nxt_limit = fsw_scale(PERIOD_MAX_MS, PRESC_MAX);
								end
							end
							MODE_SLEEP: nxt_state = ST_SLEEP;
							MODE_FLASH_SEQ: nxt_seq = (seq_ff == 2'h1) ? 2'h2 : 2'h0;
							MODE_FLASH_SERVE: begin
								if (seq_ff == 2'h2) begin
									fail_evt = 1'b1;
									fail_src = SRC_FLASH_ENTRY;
									nxt_armed = 1'b1;
									nxt_seq = 2'h0;
								end
							end
							default: begin
								fail_evt = 1'b1;
								fail_src = SRC_ILLEGAL;
							end
						endcase
					end
				end
				ST_STANDBY: begin
					if (!run_ff && flt_ff[3]) begin
						nxt_run = 1'b1;
						wd_clear = 1'b1;
						r_irq = rie_ff;
						fail_evt = !rie_ff;
						fail_src = SRC_CURRENT;
					end else if (expired && off_ff && !flt_ff[2]) begin
						nxt_run = 1'b0;
					end else if (expired && tie_ff) begin
						wd_clear = 1'b1;
						t_irq = 1'b1;
						tie_clr = 1'b1;
					end else if (expired) begin
						fail_evt = 1'b1;
						tie_clr = 1'b1;
					end else if (mode_wr && (!legal || wr_val.mode == MODE_FLASH_SEQ
						|| wr_val.mode >= MODE_FLASH_EXIT)) begin
						fail_evt = 1'b1;
						fail_src = per.ok ? SRC_ILLEGAL : SRC_WATCHDOG;
					end else if (mode_wr) begin
						wd_clear = 1'b1;
						nxt_run = 1'b1;
						nxt_off = wr_val.wd_off;
						if (!wr_val.wd_off) begin
							nxt_limit = new_limit;
						end
						if (wr_val.mode == MODE_NORMAL) begin
							nxt_state = ST_NORMAL;
						end else if (wr_val.mode == MODE_SLEEP) begin
							nxt_state = ST_SLEEP;
						end
					end else if (wake_i) begin
						fail_evt = 1'b1;
						fail_src = SRC_WAKE;
					end
				end
				ST_SLEEP: begin
					// The host is unpowered here, so supply current is not watched.
					if (expired && off_ff) begin
						nxt_run = 1'b0;
					end else if (expired) begin
						fail_evt = 1'b1;
						tie_clr = 1'b1;
					end else if (wake_i) begin
						fail_evt = 1'b1;
						fail_src = SRC_WAKE;
					end
				end
				ST_FLASH: begin
					if (expired) begin
						fail_evt = 1'b1;
						tie_clr = 1'b1;
					end else if (mode_wr && legal && wr_val.mode == MODE_FLASH_SERVE) begin
						wd_clear = 1'b1;
						nxt_limit = new_limit;
					end else if (mode_wr && legal && wr_val.mode == MODE_FLASH_EXIT) begin
						fail_evt = 1'b1;
						fail_src = SRC_FLASH_EXIT;
					end else if (mode_wr) begin
						fail_evt = 1'b1;
						fail_src = per.ok ? SRC_ILLEGAL : SRC_WATCHDOG;
					end
				end
				ST_FAILSAFE: begin
					if (wake_i) begin
						fail_evt = 1'b1;
						fail_src = SRC_WAKE;
					end
				end
				default: go_fs = 1'b1;
			endcase
			if (irq_unserved_i && state_ff != ST_SLEEP && state_ff != ST_FAILSAFE) begin
				fail_evt = 1'b1;
				fail_src = SRC_IRQ;
			end
		end
	end

	// Hardware reset causes; power-on waits for the host supply to appear.
	assign por = por_pend_ff && flt_ff[1];
	assign low_sup = sup_prev_ff && !flt_ff[1] && !por_pend_ff;
	assign ext_fall = pin_prev_ff && !flt_ff[0] && !oe_ff && !rel_chk_ff;
	assign hw_evt = por || low_sup || ext_fall;
	assign evt = !rst_active_ff && !clamp_fs && (hw_evt || fail_evt);
	assign evt_src = por ? SRC_POWER_ON : low_sup ? SRC_LOW_SUPPLY : ext_fall ? SRC_EXTERNAL :
		fail_src;
	assign clamp_fs = (rst_active_ff || rel_chk_ff) && (clamp_cnt_ff >= CLAMP_TICKS) &&
		(state_ff != ST_FAILSAFE);

	// Reset pulse stretcher and pin clamp supervision.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rst_active_ff <= 1'b0;
			rst_cnt_ff <= 5'h00;
			src_ff <= SRC_POWER_ON;
			rel_chk_ff <= 1'b0;
			clamp_cnt_ff <= 5'h00;
			por_pend_ff <= 1'b1;
			sup_prev_ff <= 1'b0;
			pin_prev_ff <= 1'b1;
			oe_ff <= 1'b0;
		end else if (ce_i) begin
			sup_prev_ff <= flt_ff[1];
			pin_prev_ff <= flt_ff[0];
			oe_ff <= rst_active_ff || state_ff == ST_SLEEP || state_ff == ST_FAILSAFE;
			if (por) begin
				por_pend_ff <= 1'b0;
			end
			if (clamp_fs) begin
				rst_active_ff <= 1'b0;
				rel_chk_ff <= 1'b0;
				clamp_cnt_ff <= 5'h00;
			end else if (evt) begin
				rst_active_ff <= 1'b1;
				// A restart sets the length bit on this same edge, so its own pulse is long too.
				rst_cnt_ff <= (rls_ff || restart) ? RST_LONG_TICKS : RST_SHORT_TICKS;
				src_ff <= evt_src;
				rel_chk_ff <= 1'b0;
				clamp_cnt_ff <= 5'h00;
			end else if (rst_active_ff) begin
				if (!flt_ff[0]) begin
					clamp_cnt_ff <= 5'h00;
				end else if (tick) begin
					clamp_cnt_ff <= 5'(clamp_cnt_ff + 5'h01);
				end
				if (tick && rst_cnt_ff == 5'h01) begin
					rst_active_ff <= 1'b0;
					rel_chk_ff <= 1'b1;
					clamp_cnt_ff <= 5'h00;
				end else if (tick) begin
					rst_cnt_ff <= 5'(rst_cnt_ff - 5'h01);
				end
			end else if (rel_chk_ff) begin
				if (flt_ff[0]) begin
					rel_chk_ff <= 1'b0;
					clamp_cnt_ff <= 5'h00;
				end else if (tick) begin
					clamp_cnt_ff <= 5'(clamp_cnt_ff + 5'h01);
				end
			end
		end
	end

	// Operating state and watchdog bookkeeping.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= ST_STARTUP;
			limit_ff <= STARTUP_TICKS;
			run_ff <= 1'b1;
			off_ff <= 1'b0;
			miss_ff <= 1'b0;
			armed_ff <= 1'b0;
			seq_ff <= 2'h0;
		end else if (ce_i) begin
			miss_ff <= nxt_miss;
			armed_ff <= nxt_armed;
			seq_ff <= nxt_seq;
			if (go_fs || clamp_fs) begin
				state_ff <= ST_FAILSAFE;
				run_ff <= 1'b0;
			end else if (evt) begin
				state_ff <= ST_STARTUP;
				run_ff <= 1'b1;
				off_ff <= 1'b0;
			end else begin
				state_ff <= nxt_state;
				limit_ff <= nxt_limit;
				run_ff <= nxt_run;
				off_ff <= nxt_off;
			end
		end
	end

	// Watchdog counter in ticks since the last accepted trigger.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wd_cnt_ff <= 16'h0000;
		end else if (ce_i) begin
			if (evt || go_fs || wd_clear || rst_active_ff) begin
				wd_cnt_ff <= 16'h0000;
			end else if (tick && run_ff) begin
				wd_cnt_ff <= 16'(wd_cnt_ff + 16'h0001);
			end
		end
	end

	// Configuration bits; a software write to the enable wins over the hardware clear.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rls_ff <= 1'b0;
			tie_ff <= 1'b0;
			rie_ff <= 1'b0;
			mode_ff <= '0;
		end else if (ce_i) begin
			if (restart || go_fs || clamp_fs) begin
				rls_ff <= 1'b1;
			end else if (cfg_wr) begin
				rls_ff <= wb_dat_i[CFG_RLS_BIT];
			end
			if (cfg_wr) begin
				tie_ff <= wb_dat_i[CFG_TIE_BIT];
				rie_ff <= wb_dat_i[CFG_RIE_BIT];
			end else if (tie_clr) begin
				tie_ff <= 1'b0;
			end
			if (mode_wr && legal) begin
				mode_ff <= wr_val;
			end
		end
	end

	// Registered outputs.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			t_irq_ff <= 1'b0;
			r_irq_ff <= 1'b0;
			fs_ff <= 1'b0;
		end else if (ce_i) begin
			t_irq_ff <= t_irq && !evt;
			r_irq_ff <= r_irq && !evt;
			fs_ff <= state_ff == ST_FAILSAFE;
		end
	end
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rd_ff;
	assign rst_pin_o = 1'b0;
	assign rst_pin_oe_o = oe_ff;
	assign timeout_irq_o = t_irq_ff;
	assign restart_irq_o = r_irq_ff;
	assign failsafe_o = fs_ff;

	a_illegal_mode_rst: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && mode_wr && !fsw_mode_ok(wr_val.mode) && per.ok && !expired && !irq_unserved_i
		&& !rst_active_ff && !hw_evt && !clamp_fs
		&& (state_ff == ST_STARTUP || state_ff == ST_NORMAL || state_ff == ST_FLASH)
		|=> rst_active_ff && src_ff == SRC_ILLEGAL)
		else $error("illegal mode code did not reset");
	a_bad_period_rst: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && mode_wr && !per.ok && (state_ff == ST_STARTUP || state_ff == ST_NORMAL) && !expired
		&& !rst_active_ff
		&& !hw_evt && !clamp_fs && !irq_unserved_i |=> rst_active_ff && src_ff == SRC_WATCHDOG)
		else $error("illegal period code did not reset");
	a_early_trigger: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && state_ff == ST_NORMAL && mode_wr && legal && wd_cnt_ff < (limit_ff >> 1)
		&& !rst_active_ff && !hw_evt && !clamp_fs |=> rst_active_ff ##1 state_ff == ST_STARTUP)
		else $error("early trigger not caught");
	a_pin_follows: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && rst_active_ff ##1 ce_i |-> rst_pin_oe_o)
		else $error("reset pin not driven during pulse");
	a_stretch_load: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(rst_active_ff) |-> rst_cnt_ff == (($past(rls_ff) || $past(restart)) ? RST_LONG_TICKS
		: RST_SHORT_TICKS))
		else $error("stretch length not taken from length select");
	a_source_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!evt |=> $stable(src_ff))
		else $error("reset source changed without an event");
	a_tie_cleared: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && tie_clr && !cfg_wr |=> !tie_ff)
		else $error("time-out interrupt enable not cleared");
	a_second_miss: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && state_ff == ST_STARTUP && expired && miss_ff && !mode_wr |=> state_ff == ST_FAILSAFE
		&& !run_ff)
		else $error("second start-up miss did not fail safe");
	a_off_stop: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && state_ff == ST_STANDBY && run_ff && expired && off_ff && !flt_ff[2] && !hw_evt
		&& !irq_unserved_i |=> !run_ff)
		else $error("watchdog did not stop once current was low");
	a_restart_len: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && (restart || go_fs) |=> rls_ff)
		else $error("length select not set on restart");

endmodule // fsw_watchdog_reset

// ==== fsw_pkg.sv ====
// Constants, field layouts and helper functions of the fail-safe watchdog and reset controller.
package fsw_pkg;

	// Clock rate and the watchdog tick, which is the time base of every timer.
	localparam int CLK_FREQ_HZ = 10000000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = TICK_US * (CLK_FREQ_HZ / 1000000);

	// Reset stretch lengths in milliseconds and in ticks.
	localparam int RST_SHORT_MS = 1;
	localparam int RST_LONG_MS = 20;
	localparam logic [4:0] RST_SHORT_TICKS = 5'(RST_SHORT_MS * 1000 / TICK_US);
	localparam logic [4:0] RST_LONG_TICKS = 5'(RST_LONG_MS * 1000 / TICK_US);

	// Start-up service limit and reset pin clamp limit, in milliseconds and ticks.
	localparam int STARTUP_LIMIT_MS = 256;
	localparam logic [15:0] STARTUP_TICKS = 16'(STARTUP_LIMIT_MS * 1000 / TICK_US);
	localparam int CLAMP_MS = 10;
	localparam logic [4:0] CLAMP_TICKS = 5'(CLAMP_MS * 1000 / TICK_US);

	// Register byte offsets on the bus.
	localparam logic [7:0] REG_MODE = 8'h00;
	localparam logic [7:0] REG_CONFIG = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;

	// Configuration register bit positions.
	localparam int CFG_RLS_BIT = 0;
	localparam int CFG_TIE_BIT = 1;
	localparam int CFG_RIE_BIT = 2;

	// Operating mode codes; 000 and 010 are illegal.
	localparam logic [2:0] MODE_FLASH_SEQ = 3'h1;
	localparam logic [2:0] MODE_STANDBY = 3'h3;
	localparam logic [2:0] MODE_SLEEP = 3'h4;
	localparam logic [2:0] MODE_NORMAL = 3'h5;
	localparam logic [2:0] MODE_FLASH_EXIT = 3'h6;
	localparam logic [2:0] MODE_FLASH_SERVE = 3'h7;

	// Reset source codes.
	localparam logic [3:0] SRC_POWER_ON = 4'h0;
	localparam logic [3:0] SRC_LOW_SUPPLY = 4'h1;
	localparam logic [3:0] SRC_CURRENT = 4'h2;
	localparam logic [3:0] SRC_EXTERNAL = 4'h3;
	localparam logic [3:0] SRC_FLASH_ENTRY = 4'h6;
	localparam logic [3:0] SRC_FLASH_EXIT = 4'h7;
	localparam logic [3:0] SRC_WAKE = 4'h8;
	localparam logic [3:0] SRC_WATCHDOG = 4'h9;
	localparam logic [3:0] SRC_ILLEGAL = 4'hA;
	localparam logic [3:0] SRC_IRQ = 4'hB;

	// Longest period: largest nominal value with the largest prescaler.
	localparam logic [11:0] PERIOD_MAX_MS = 12'h800;
	localparam logic [1:0] PRESC_MAX = 2'h3;

	// Mode register layout, one 32-bit word.
	typedef struct packed {
		logic [20:0] rsvd;
		logic wd_off;
		logic [1:0] presc;
		logic [4:0] period;
		logic [2:0] mode;
	} fsw_mode_reg_t;

	// Decoded period code.
	typedef struct packed {
		logic ok;
		logic [11:0] ms;
	} fsw_period_t;

	// Operating state, Gray coded along start-up, normal, standby, sleep.
	typedef enum logic [2:0] {
		ST_STARTUP = 3'h0,
		ST_NORMAL = 3'h1,
		ST_STANDBY = 3'h3,
		ST_SLEEP = 3'h2,
		ST_FLASH = 3'h6,
		ST_FAILSAFE = 3'h4
	} fsw_state_t;

	// Ten redundant period codes, each at least two bits apart from every other code.
	function automatic fsw_period_t fsw_period(input logic [4:0] code);
		unique case (code)
			5'h03: return {1'b1, 12'h004};
			5'h05: return {1'b1, 12'h008};
			5'h06: return {1'b1, 12'h010};
			5'h09: return {1'b1, 12'h020};
			5'h0A: return {1'b1, 12'h040};
			5'h0C: return {1'b1, 12'h080};
			5'h11: return {1'b1, 12'h100};
			5'h12: return {1'b1, 12'h200};
			5'h14: return {1'b1, 12'h400};
			5'h18: return {1'b1, PERIOD_MAX_MS};
			default: return {1'b0, 12'h000};
		endcase
	endfunction

	// Six legal mode codes.
	function automatic logic fsw_mode_ok(input logic [2:0] code);
		return (code != 3'h0) && (code != 3'h2);
	endfunction

	// Period in ticks after the prescaler.
	function automatic logic [15:0] fsw_scale(input logic [11:0] ms, input logic [1:0] p);
		return {4'h0, ms} << p;
	endfunction

endpackage

// ==== fsw_host_model.sv ====
// Host side model: reset wire with pull-up, host supply and current sensing.
`timescale 1ns/1ps
module fsw_host_model (
	input wire logic pin_pull_i,
	output logic pin_level_o,
	output logic supply_ok_o,
	output logic cur_low_o,
	output logic cur_high_o
);
	// The pull-up lifts the wire whenever the controller lets go.
	assign pin_level_o = !pin_pull_i;
	// Host supply is present from the start, so power-on can complete.
	assign supply_ok_o = 1'b1;
	// Current stays high; the off option is not exercised here, a known gap.
	assign cur_low_o = 1'b1;
	assign cur_high_o = 1'b1;
endmodule // fsw_host_model

// ==== tb_top.sv ====
// Self-checking bench for the watchdog and reset controller.
`timescale 1ns/1ps
module tb_top;
	import fsw_pkg::*;
	// Cycles per tick, short for simulation but above the pin synchroniser's latency,
	// so that the design never mistakes the echo of its own short pulse for an external edge.
	localparam int TK = 8;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h00000000, q, rdo;
	logic ack, oe, pin, sup, clo, chi, fs, tirq;
	int miscompares = 0, comparisons = 0, cycles = 0, len;
	always #50 clk_i = !clk_i;
	fsw_host_model host (.pin_pull_i(oe), .pin_level_o(pin), .supply_ok_o(sup),
		.cur_low_o(clo), .cur_high_o(chi));
	fsw_watchdog_reset #(.TICK_CYCLES_P(TK)) uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack), .rst_pin_i(pin), .rst_pin_o(),
		.rst_pin_oe_o(oe), .supply_ok_i(sup), .cur_above_low_i(clo), .cur_above_high_i(chi),
		.wake_i(1'b0), .irq_unserved_i(1'b0), .timeout_irq_o(tirq), .restart_irq_o(),
		.failsafe_o(fs));
	// Ends the run with the counts and the verdict.
	task automatic print_verdict();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Classic single cycle: the request stands until the rising edge at which ack is high.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdo;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// Waits for the reset pulse and measures how many cycles the pin is pulled.
	task automatic pulse(input int lim, input logic [4:0] ticks);
		int n;
		n = 0;
		while (oe !== 1'b1 && n < lim) begin
			@(negedge clk_i); n++;
		end
		len = 0;
		while (oe === 1'b1 && len < 200) begin
			@(negedge clk_i); len++;
		end
		chk(len >= ticks * TK - TK + 1 && len <= ticks * TK + TK, 1'b1);
	endtask
	task automatic src(input logic [3:0] s, input logic [2:0] st);
		wb(1'b0, REG_STATUS, 32'h0);
		chk({q[6:4], q[3:0]}, {st, s});
	endtask
	// The timeout counts as a mismatch so a hang still reaches the verdict.
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles > 20000) begin
			miscompares++;
			print_verdict();
		end
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		pulse(50, RST_SHORT_TICKS);
		src(SRC_POWER_ON, 3'h0);
		wb(1'b1, REG_MODE, 32'h0000004D);
		src(SRC_POWER_ON, 3'h1);
		wb(1'b0, REG_MODE, 32'h0);
		chk(q, 32'h0000004D);
		wb(1'b0, 8'h0C, 32'h0);
		chk(q, 32'h0);
		repeat (180) @(posedge clk_i);
		wb(1'b1, REG_MODE, 32'h0000004D);
		src(SRC_POWER_ON, 3'h1);
		wb(1'b1, REG_MODE, 32'h0000004D);
		pulse(50, RST_SHORT_TICKS);
		src(SRC_WATCHDOG, 3'h0);
		wb(1'b1, REG_MODE, 32'h00000048);
		pulse(50, RST_SHORT_TICKS);
		src(SRC_ILLEGAL, 3'h0);
		wb(1'b1, REG_MODE, 32'h00000005);
		pulse(50, RST_SHORT_TICKS);
		src(SRC_WATCHDOG, 3'h0);
		wb(1'b1, REG_MODE, 32'h0000004D);
		pulse(400, RST_SHORT_TICKS);
		src(SRC_WATCHDOG, 3'h0);
		pulse(2400, RST_LONG_TICKS);
		wb(1'b0, REG_CONFIG, 32'h0);
		chk(q[CFG_RLS_BIT], 1'b1);
		len = 0;
		while (fs !== 1'b1 && len < 2400) begin
			@(negedge clk_i); len++;
		end
		chk(fs, 1'b1);
		// A second reset in mid-run, then one standby cycle with the time-out interrupt.
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		pulse(50, RST_SHORT_TICKS);
		wb(1'b1, REG_CONFIG, 32'h00000002);
		wb(1'b0, REG_CONFIG, 32'h0);
		chk(q[CFG_TIE_BIT], 1'b1);
		wb(1'b1, REG_MODE, 32'h0000004B);
		src(SRC_POWER_ON, 3'h3);
		len = 0;
		while (tirq !== 1'b1 && len < 400) begin
			@(negedge clk_i);
			len++;
		end
		chk(tirq, 1'b1);
		wb(1'b0, REG_CONFIG, 32'h0);
		chk(q[CFG_TIE_BIT], 1'b0);
		// With the enable gone, the next expiry must reset instead of interrupting.
		pulse(400, RST_SHORT_TICKS);
		src(SRC_WATCHDOG, 3'h0);
		print_verdict();
	end
endmodule // tb_top
